// >>> rtl/drive_command_protocol.sv
// Control bus command interpreter of the drive
// Summary of operation
// [RULE1] Each command is an opcode byte then one parameter byte.
// [RULE2] Opcode flows in; parameter direction follows the direction line.
// [RULE3] Opcodes with top bit set raise attention and the illegal flag.
// [RULE4] Opcode-only commands return the general status byte.
// [RULE5] Immediate mechanical actions delay the second acknowledge until done.
// [RULE6] A failed immediate action raises attention before that acknowledge; here attention is set on the same edge as the acknowledge.
// [RULE7] Deferred operations raise attention when their action finishes.
// [RULE8] Deferred operation completes only when its attention is cleared.
// [RULE9] Commands run on parameter values captured when they start.
// [RULE10] Overlapping deferred command while not busy is rejected with attention.
// [RULE11] Host starts a new deferred command only after the last completes.
// [RULE12] Immediate commands still accepted during a deferred one if not busy.
// [RULE13] 42h loads cylinder high byte, 43h the low byte.
// [RULE14] Head select: 44h immediate, 45h deferred, head number goes out.
// [RULE15] Opcode ranges split mandatory, optional and vendor groups.
// [RULE16] Spin opcode only with strap; without strap spin up at power-on.
// [RULE17] Read and write permit limits allow cylinders at or above them.
// [RULE18] Bytes per sector and sector pulses are three-byte loads.
// [RULE19] 00h and 11h raise attention and return general status.
// [RULE20] Seek, rezero, reset, outer stop, partition are deferred.
// [RULE21] Reports return cylinder address and both permit limits.
// [RULE22] Unused parameter bits are driven as zero.
// [RULE23] Attention clears only by service acknowledge or fault reset.
// [RULE24] Opcode request during busy waits for busy to drop.
// [RULE25] Strobe and offset parameters decode from bits 7 and 6.
`timescale 1ns/1ps
`default_nettype none
module drive_command_protocol (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic cmd_req,
	input wire logic par_req,
	input wire logic dir_out,
	input wire logic [7:0] bus_in,
	output logic [7:0] bus_out,
	output logic bus_out_en,
	output logic bus_ack,
	output logic busy,
	output logic attention,
	input wire logic spin_strap,
	input wire logic mech_busy,
	input wire logic act_done,
	input wire logic act_fail,
	input wire logic [15:0] cur_cyl,
	output logic act_start,
	output logic [7:0] act_code,
	output logic [15:0] act_cyl,
	output logic [7:0] act_param,
	output logic [7:0] head_sel,
	output logic [1:0] strobe_mode,
	output logic [1:0] offset_mode,
	output logic spin_on,
	output logic write_en,
	output logic [15:0] target_cyl,
	output logic [23:0] bytes_per_sector,
	output logic [23:0] sectors_per_track,
	output logic read_permit,
	output logic write_permit
);
	drive_cmd_pkg::state_t state;
	logic [1:0] cmd_sync, par_sync, dir_sync, strap_sync;
	logic [7:0] data_s1, data_s2;
	logic cmd_s, par_s, dir_s, strap_s;
	logic [7:0] opcode, gstat, sense1, test_byte, resp;
	logic [15:0] rd_limit, wr_limit;
	logic attn, attn_en, td_active, init_done, illegal_flag;
	logic legal, param_out, deferred, mech_imm;
	logic par_take, clr_attn, clr_fault, set_attn, set_illegal, set_reject;

	assign cmd_s = cmd_sync[1];
	assign par_s = par_sync[1];
	assign dir_s = dir_sync[1];
	assign strap_s = strap_sync[1];

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			cmd_sync <= 2'h0;
			par_sync <= 2'h0;
			dir_sync <= 2'h0;
			strap_sync <= 2'h0;
			data_s1 <= drive_cmd_pkg::BYTE_ZERO;
			data_s2 <= drive_cmd_pkg::BYTE_ZERO;
		end else if (clk_en) begin
			cmd_sync <= {cmd_sync[0], cmd_req};
			par_sync <= {par_sync[0], par_req};
			dir_sync <= {dir_sync[0], dir_out};
			strap_sync <= {strap_sync[0], spin_strap};
			data_s1 <= bus_in;
			data_s2 <= data_s1;
		end
	end

	opcode_class u_class (
		.opcode(opcode),
		.spin_strap(strap_s),
		.legal(legal),
		.param_out(param_out),
		.deferred(deferred),
		.mech_imm(mech_imm)
	);

	// ----------------------------------------------------------------
	// Decode of the parameter phase
	// ----------------------------------------------------------------
	assign busy = mech_busy;
	assign par_take = clk_en && state == drive_cmd_pkg::ST_WAIT_PAR && par_s;
	assign clr_fault = par_take && legal && opcode == drive_cmd_pkg::OP_CLEAR_FAULT;
	assign clr_attn = clr_fault
		|| (par_take && legal && opcode == drive_cmd_pkg::OP_SERVICE_ACK); // see [RULE23]
	assign set_illegal = par_take && !legal; // see [RULE3] see [RULE15]
	assign set_reject = par_take && deferred && td_active && !busy; // see [RULE10]
	assign set_attn = set_illegal || set_reject
		|| (par_take && legal && (opcode == drive_cmd_pkg::OP_REPORT_UNKNOWN
		|| opcode == drive_cmd_pkg::OP_SET_ATTN)) // see [RULE19]
		|| (clk_en && state == drive_cmd_pkg::ST_EXEC && act_done && act_fail) // see [RULE6]
		|| (clk_en && td_active && act_done); // see [RULE7]

	always_comb begin
		gstat = drive_cmd_pkg::BYTE_ZERO;
		gstat[drive_cmd_pkg::GS_ATTN_BIT] = attn;
		gstat[drive_cmd_pkg::GS_ILLEGAL_BIT] = sense1[drive_cmd_pkg::S1_FAIL_BIT]
			| illegal_flag;
		gstat[drive_cmd_pkg::GS_BUSY_BIT] = busy;
		gstat[drive_cmd_pkg::GS_TD_BIT] = td_active;
	end

	// Parameter-in answer, unused bits zero
	always_comb begin
		resp = gstat; // see [RULE4]
		unique case (opcode)
			drive_cmd_pkg::OP_REPORT_SENSE1: resp = sense1;
			drive_cmd_pkg::OP_REPORT_SENSE2: begin
				resp = drive_cmd_pkg::BYTE_ZERO; // see [RULE22]
				resp[drive_cmd_pkg::S2_WPROT_BIT] = !write_en;
			end
			drive_cmd_pkg::OP_RPT_CYL_HI: resp = cur_cyl[15:8]; // see [RULE21]
			drive_cmd_pkg::OP_RPT_CYL_LO: resp = cur_cyl[7:0];
			drive_cmd_pkg::OP_RPT_RD_HI: resp = rd_limit[15:8];
			drive_cmd_pkg::OP_RPT_RD_LO: resp = rd_limit[7:0];
			drive_cmd_pkg::OP_RPT_WR_HI: resp = wr_limit[15:8];
			drive_cmd_pkg::OP_RPT_WR_LO: resp = wr_limit[7:0];
			drive_cmd_pkg::OP_RPT_TEST: resp = test_byte;
			default: resp = gstat;
		endcase
	end

	// ----------------------------------------------------------------
	// Handshake sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= drive_cmd_pkg::ST_IDLE;
			bus_ack <= 1'b0;
			bus_out <= drive_cmd_pkg::BYTE_ZERO;
			bus_out_en <= 1'b0;
			opcode <= drive_cmd_pkg::BYTE_ZERO;
		end else if (clk_en) begin
			unique case (state)
				drive_cmd_pkg::ST_IDLE: begin
					if (cmd_s && !busy) begin // see [RULE24] see [RULE12]
						opcode <= data_s2; // see [RULE1]
						bus_ack <= 1'b1;
						state <= drive_cmd_pkg::ST_CMD_ACK;
					end
				end
				drive_cmd_pkg::ST_CMD_ACK: begin
					if (!cmd_s) begin
						bus_ack <= 1'b0;
						state <= drive_cmd_pkg::ST_WAIT_PAR;
					end
				end
				drive_cmd_pkg::ST_WAIT_PAR: begin
					if (par_s) begin
						if (!dir_s) begin // see [RULE2]
							bus_out <= resp;
							bus_out_en <= 1'b1;
						end
						if (mech_imm && !param_out) begin
							state <= drive_cmd_pkg::ST_EXEC;
						end else if (mech_imm) begin
							state <= drive_cmd_pkg::ST_EXEC; // see [RULE5]
						end else begin
							bus_ack <= 1'b1;
							state <= drive_cmd_pkg::ST_PAR_ACK;
						end
					end
				end
				drive_cmd_pkg::ST_EXEC: begin
					if (act_done) begin // see [RULE5]
						bus_ack <= 1'b1;
						state <= drive_cmd_pkg::ST_PAR_ACK;
					end
				end
				drive_cmd_pkg::ST_PAR_ACK: begin
					if (!par_s) begin
						bus_ack <= 1'b0;
						bus_out <= drive_cmd_pkg::BYTE_ZERO; // see [RULE22]
						bus_out_en <= 1'b0;
						state <= drive_cmd_pkg::ST_IDLE;
					end
				end
				default: state <= drive_cmd_pkg::ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Attention, status flags and deferred tracking
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			attn <= 1'b0;
			illegal_flag <= 1'b0;
			sense1 <= drive_cmd_pkg::BYTE_ZERO;
			td_active <= 1'b0;
		end else if (clk_en) begin
			if (set_attn) begin
				attn <= 1'b1; // set wins over clear
			end else if (clr_attn) begin
				attn <= 1'b0; // see [RULE23]
			end
			if (set_illegal) begin
				illegal_flag <= 1'b1; // see [RULE3]
			end else if (clr_fault) begin
				illegal_flag <= 1'b0;
			end
			if (set_reject) begin
				sense1[drive_cmd_pkg::S1_REJECT_BIT] <= 1'b1; // see [RULE10]
			end else if (clr_fault) begin
				sense1[drive_cmd_pkg::S1_REJECT_BIT] <= 1'b0;
			end
			if (state == drive_cmd_pkg::ST_EXEC && act_done && act_fail) begin
				sense1[drive_cmd_pkg::S1_FAIL_BIT] <= 1'b1; // see [RULE6]
			end else if (clr_fault) begin
				sense1[drive_cmd_pkg::S1_FAIL_BIT] <= 1'b0;
			end
			if (par_take && deferred && !td_active) begin
				td_active <= 1'b1;
			end else if (td_active && attn && clr_attn && !set_attn) begin
				td_active <= 1'b0; // see [RULE8]
			end
		end
	end

	assign attention = attn && attn_en;

	// ----------------------------------------------------------------
	// Action launch with captured parameters
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			act_start <= 1'b0;
			act_code <= drive_cmd_pkg::BYTE_ZERO;
			act_cyl <= drive_cmd_pkg::CYL_ZERO;
			act_param <= drive_cmd_pkg::BYTE_ZERO;
		end else if (clk_en) begin
			act_start <= 1'b0;
			if (par_take && (mech_imm || (deferred && !td_active))) begin
				act_start <= 1'b1;
				act_code <= opcode;
				act_cyl <= target_cyl; // see [RULE9]
				act_param <= param_out ? data_s2 : drive_cmd_pkg::BYTE_ZERO;
			end
		end
	end

	// ----------------------------------------------------------------
	// Parameter-out loads
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			attn_en <= 1'b1;
			write_en <= 1'b0;
			target_cyl <= drive_cmd_pkg::CYL_ZERO;
			head_sel <= drive_cmd_pkg::BYTE_ZERO;
			strobe_mode <= drive_cmd_pkg::MODE_NOMINAL;
			offset_mode <= drive_cmd_pkg::MODE_NOMINAL;
			bytes_per_sector <= drive_cmd_pkg::WIDE_ZERO;
			sectors_per_track <= drive_cmd_pkg::WIDE_ZERO;
			rd_limit <= drive_cmd_pkg::CYL_ZERO;
			wr_limit <= drive_cmd_pkg::CYL_ZERO;
			test_byte <= drive_cmd_pkg::BYTE_ZERO;
		end else if (clk_en && par_take && legal && param_out && !set_reject) begin
			unique case (opcode)
				drive_cmd_pkg::OP_ATTN_CTRL: attn_en <= !data_s2[drive_cmd_pkg::PARAM_FLAG_BIT];
				drive_cmd_pkg::OP_WRITE_CTRL: write_en <= data_s2[drive_cmd_pkg::PARAM_FLAG_BIT];
				drive_cmd_pkg::OP_CYL_HI: target_cyl[15:8] <= data_s2; // see [RULE13]
				drive_cmd_pkg::OP_CYL_LO: target_cyl[7:0] <= data_s2; // see [RULE13]
				drive_cmd_pkg::OP_HEAD_IMM, drive_cmd_pkg::OP_HEAD_TD: head_sel <= data_s2; // see [RULE14]
				drive_cmd_pkg::OP_READ_STROBE: strobe_mode <= mode_of(data_s2); // see [RULE25]
				drive_cmd_pkg::OP_HEAD_OFFSET: offset_mode <= mode_of(data_s2); // see [RULE25]
				drive_cmd_pkg::OP_BPS_HI: bytes_per_sector[23:16] <= data_s2; // see [RULE18]
				drive_cmd_pkg::OP_BPS_MID: bytes_per_sector[15:8] <= data_s2;
				drive_cmd_pkg::OP_BPS_LO: bytes_per_sector[7:0] <= data_s2;
				drive_cmd_pkg::OP_SPT_HI: sectors_per_track[23:16] <= data_s2;
				drive_cmd_pkg::OP_SPT_MID: sectors_per_track[15:8] <= data_s2;
				drive_cmd_pkg::OP_SPT_LO: sectors_per_track[7:0] <= data_s2;
				drive_cmd_pkg::OP_RD_LIM_HI: rd_limit[15:8] <= data_s2; // see [RULE17]
				drive_cmd_pkg::OP_RD_LIM_LO: rd_limit[7:0] <= data_s2;
				drive_cmd_pkg::OP_WR_LIM_HI: wr_limit[15:8] <= data_s2;
				drive_cmd_pkg::OP_WR_LIM_LO: wr_limit[7:0] <= data_s2;
				drive_cmd_pkg::OP_LOAD_TEST: test_byte <= data_s2;
				default: test_byte <= test_byte;
			endcase
		end
	end

	function automatic logic [1:0] mode_of(input logic [7:0] p);
		if (!p[drive_cmd_pkg::PARAM_FLAG_BIT]) begin
			mode_of = drive_cmd_pkg::MODE_NOMINAL;
		end else if (!p[drive_cmd_pkg::PARAM_SUB_BIT]) begin
			mode_of = drive_cmd_pkg::MODE_EARLY;
		end else begin
			mode_of = drive_cmd_pkg::MODE_LATE;
		end
	endfunction

	// Spin: strap-less drive spins up once reset is released
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			spin_on <= 1'b0;
			init_done <= 1'b0;
		end else if (clk_en) begin
			init_done <= 1'b1;
			if (!init_done && !strap_s) begin
				spin_on <= 1'b1; // see [RULE16]
			end else if (par_take && legal && opcode == drive_cmd_pkg::OP_SPIN && !set_reject) begin
				spin_on <= data_s2[drive_cmd_pkg::PARAM_FLAG_BIT]; // see [RULE16]
			end
		end
	end

	assign read_permit = cur_cyl >= rd_limit; // see [RULE17]
	assign write_permit = write_en && cur_cyl >= wr_limit; // see [RULE17]

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_busy_hold: assert property (@(posedge sys_clk) disable iff (!reset_n) // see [RULE24]
		(clk_en && state == drive_cmd_pkg::ST_IDLE && busy) |=> !bus_ack)
		else $error("ack given while busy");
	a_reserved_attn: assert property (@(posedge sys_clk) disable iff (!reset_n) // see [RULE3]
		(par_take && opcode[drive_cmd_pkg::RESERVED_BIT]) |=> (attn && illegal_flag))
		else $error("reserved opcode not flagged");
	a_imm_wait: assert property (@(posedge sys_clk) disable iff (!reset_n) // see [RULE5]
		(clk_en && state == drive_cmd_pkg::ST_EXEC && !act_done) |=> !bus_ack)
		else $error("ack before action done");
	a_fail_before_ack: assert property (@(posedge sys_clk) disable iff (!reset_n) // see [RULE6]
		(clk_en && state == drive_cmd_pkg::ST_EXEC && act_done && act_fail)
		|=> (attn && bus_ack))
		else $error("failed action without attention");
	a_td_finish: assert property (@(posedge sys_clk) disable iff (!reset_n) // see [RULE7]
		(clk_en && td_active && act_done) |=> attn)
		else $error("deferred finish without attention");
	a_td_complete: assert property (@(posedge sys_clk) disable iff (!reset_n) // see [RULE8]
		$fell(td_active) |-> ($past(attn) && !attn))
		else $error("deferred ended without clear");
	a_td_reject: assert property (@(posedge sys_clk) disable iff (!reset_n) // see [RULE10]
		set_reject |=> (attn && sense1[drive_cmd_pkg::S1_REJECT_BIT] && !act_start))
		else $error("overlap not rejected");
	a_cyl_high: assert property (@(posedge sys_clk) disable iff (!reset_n) // see [RULE13]
		(par_take && legal && opcode == drive_cmd_pkg::OP_CYL_HI)
		|=> target_cyl[15:8] == $past(data_s2))
		else $error("cylinder high not loaded");
	a_idle_zero: assert property (@(posedge sys_clk) disable iff (!reset_n) // see [RULE22]
		!bus_out_en |-> bus_out == drive_cmd_pkg::BYTE_ZERO)
		else $error("bus not zero when idle");
	a_attn_sticky: assert property (@(posedge sys_clk) disable iff (!reset_n) // see [RULE23]
		(attn && !clr_attn) |=> attn)
		else $error("attention dropped without clear");
endmodule
`default_nettype wire

// >>> rtl/drive_cmd_pkg.sv
// Package: opcodes, status bit positions, modes and states of the command block
package drive_cmd_pkg;

	// ----------------------------------------------------------------
	// Opcodes
	// ----------------------------------------------------------------
	localparam logic [7:0] OP_REPORT_UNKNOWN = 8'h00;
	localparam logic [7:0] OP_CLEAR_FAULT = 8'h01;
	localparam logic [7:0] OP_SERVICE_ACK = 8'h02;
	localparam logic [7:0] OP_SEEK = 8'h03;
	localparam logic [7:0] OP_REZERO = 8'h04;
	localparam logic [7:0] OP_REPORT_SENSE2 = 8'h0D;
	localparam logic [7:0] OP_REPORT_SENSE1 = 8'h0E;
	localparam logic [7:0] OP_REPORT_STATUS = 8'h0F;
	localparam logic [7:0] OP_SET_ATTN = 8'h11;
	localparam logic [7:0] OP_SEL_RESET = 8'h14;
	localparam logic [7:0] OP_SEEK_OUTER = 8'h15;
	localparam logic [7:0] OP_PARTITION = 8'h16;
	localparam logic [7:0] OP_RPT_CYL_HI = 8'h29;
	localparam logic [7:0] OP_RPT_CYL_LO = 8'h2A;
	localparam logic [7:0] OP_RPT_RD_HI = 8'h2B;
	localparam logic [7:0] OP_RPT_RD_LO = 8'h2C;
	localparam logic [7:0] OP_RPT_WR_HI = 8'h2D;
	localparam logic [7:0] OP_RPT_WR_LO = 8'h2E;
	localparam logic [7:0] OP_RPT_TEST = 8'h2F;
	localparam logic [7:0] OP_ATTN_CTRL = 8'h40;
	localparam logic [7:0] OP_WRITE_CTRL = 8'h41;
	localparam logic [7:0] OP_CYL_HI = 8'h42;
	localparam logic [7:0] OP_CYL_LO = 8'h43;
	localparam logic [7:0] OP_HEAD_IMM = 8'h44;
	localparam logic [7:0] OP_HEAD_TD = 8'h45;
	localparam logic [7:0] OP_READ_STROBE = 8'h53;
	localparam logic [7:0] OP_HEAD_OFFSET = 8'h54;
	localparam logic [7:0] OP_SPIN = 8'h55;
	localparam logic [7:0] OP_BPS_HI = 8'h56;
	localparam logic [7:0] OP_BPS_MID = 8'h57;
	localparam logic [7:0] OP_BPS_LO = 8'h58;
	localparam logic [7:0] OP_SPT_HI = 8'h59;
	localparam logic [7:0] OP_SPT_MID = 8'h5A;
	localparam logic [7:0] OP_SPT_LO = 8'h5B;
	localparam logic [7:0] OP_RD_LIM_HI = 8'h6B;
	localparam logic [7:0] OP_RD_LIM_LO = 8'h6C;
	localparam logic [7:0] OP_WR_LIM_HI = 8'h6D;
	localparam logic [7:0] OP_WR_LIM_LO = 8'h6E;
	localparam logic [7:0] OP_LOAD_TEST = 8'h6F;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int RESERVED_BIT = 7;
	localparam int DIR_BIT = 6;
	localparam int PARAM_FLAG_BIT = 7;
	localparam int PARAM_SUB_BIT = 6;
	localparam int GS_ATTN_BIT = 0;
	localparam int GS_ILLEGAL_BIT = 1;
	localparam int GS_BUSY_BIT = 2;
	localparam int GS_TD_BIT = 3;
	localparam int S1_FAIL_BIT = 0;
	localparam int S1_REJECT_BIT = 6;
	localparam int S2_WPROT_BIT = 0;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [15:0] CYL_ZERO = 16'h0000;
	localparam logic [23:0] WIDE_ZERO = 24'h000000;

	// ----------------------------------------------------------------
	// Strobe and offset modes
	// ----------------------------------------------------------------
	localparam logic [1:0] MODE_NOMINAL = 2'h0;
	localparam logic [1:0] MODE_EARLY = 2'h1;
	localparam logic [1:0] MODE_LATE = 2'h2;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_CMD_ACK = 3'b001,
		ST_WAIT_PAR = 3'b010,
		ST_EXEC = 3'b011,
		ST_PAR_ACK = 3'b100
	} state_t;

endpackage

// >>> rtl/opcode_class.sv
// Opcode classifier: legality, parameter direction and completion class
`timescale 1ns/1ps
`default_nettype none
module opcode_class (
	input wire logic [7:0] opcode,
	input wire logic spin_strap,
	output logic legal,
	output logic param_out,
	output logic deferred,
	output logic mech_imm
);
	// ----------------------------------------------------------------
	// Known opcode table
	// ----------------------------------------------------------------
	function automatic logic known(input logic [7:0] op, input logic strap);
		unique case (op)
			drive_cmd_pkg::OP_REPORT_UNKNOWN, drive_cmd_pkg::OP_CLEAR_FAULT,
			drive_cmd_pkg::OP_SERVICE_ACK, drive_cmd_pkg::OP_SEEK,
			drive_cmd_pkg::OP_REZERO, drive_cmd_pkg::OP_REPORT_SENSE2,
			drive_cmd_pkg::OP_REPORT_SENSE1, drive_cmd_pkg::OP_REPORT_STATUS,
			drive_cmd_pkg::OP_SET_ATTN, drive_cmd_pkg::OP_SEL_RESET,
			drive_cmd_pkg::OP_SEEK_OUTER, drive_cmd_pkg::OP_PARTITION,
			drive_cmd_pkg::OP_RPT_CYL_HI, drive_cmd_pkg::OP_RPT_CYL_LO,
			drive_cmd_pkg::OP_RPT_RD_HI, drive_cmd_pkg::OP_RPT_RD_LO,
			drive_cmd_pkg::OP_RPT_WR_HI, drive_cmd_pkg::OP_RPT_WR_LO,
			drive_cmd_pkg::OP_RPT_TEST, drive_cmd_pkg::OP_ATTN_CTRL,
			drive_cmd_pkg::OP_WRITE_CTRL, drive_cmd_pkg::OP_CYL_HI,
			drive_cmd_pkg::OP_CYL_LO, drive_cmd_pkg::OP_HEAD_IMM,
			drive_cmd_pkg::OP_HEAD_TD, drive_cmd_pkg::OP_READ_STROBE,
			drive_cmd_pkg::OP_HEAD_OFFSET, drive_cmd_pkg::OP_BPS_HI,
			drive_cmd_pkg::OP_BPS_MID, drive_cmd_pkg::OP_BPS_LO,
			drive_cmd_pkg::OP_SPT_HI, drive_cmd_pkg::OP_SPT_MID,
			drive_cmd_pkg::OP_SPT_LO, drive_cmd_pkg::OP_RD_LIM_HI,
			drive_cmd_pkg::OP_RD_LIM_LO, drive_cmd_pkg::OP_WR_LIM_HI,
			drive_cmd_pkg::OP_WR_LIM_LO, drive_cmd_pkg::OP_LOAD_TEST: known = 1'b1;
			drive_cmd_pkg::OP_SPIN: known = strap; // see [RULE16]
			default: known = 1'b0; // see [RULE15]
		endcase
	endfunction

	// ----------------------------------------------------------------
	// Classification
	// ----------------------------------------------------------------
	always_comb begin
		legal = !opcode[drive_cmd_pkg::RESERVED_BIT] && known(opcode, spin_strap); // see [RULE3]
		param_out = opcode[drive_cmd_pkg::DIR_BIT]; // see [RULE2]
		deferred = legal && (opcode == drive_cmd_pkg::OP_SEEK ||
			opcode == drive_cmd_pkg::OP_REZERO ||
			opcode == drive_cmd_pkg::OP_SEL_RESET ||
			opcode == drive_cmd_pkg::OP_SEEK_OUTER ||
			opcode == drive_cmd_pkg::OP_PARTITION ||
			opcode == drive_cmd_pkg::OP_HEAD_TD ||
			opcode == drive_cmd_pkg::OP_HEAD_OFFSET ||
			opcode == drive_cmd_pkg::OP_SPIN); // see [RULE20] see [RULE14]
		mech_imm = legal && (opcode == drive_cmd_pkg::OP_HEAD_IMM ||
			opcode == drive_cmd_pkg::OP_READ_STROBE); // see [RULE14]
	end
endmodule
`default_nettype wire

// >>> sim/host_model.sv
// Host controller model driving the control bus handshake
`timescale 1ns/1ps
`default_nettype none
module host_model (
	input wire logic sys_clk,
	input wire logic bus_ack,
	output logic cmd_req,
	output logic par_req,
	output logic dir_out,
	output logic [7:0] bus_in,
	output logic hang
);
	initial begin
		cmd_req = 1'b0;
		par_req = 1'b0;
		dir_out = 1'b1;
		bus_in = 8'h5A;
		hang = 1'b0;
	end
	task automatic wait_ack(input logic lvl);
		int n;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (bus_ack !== lvl && n < 400);
		if (n >= 400) hang <= 1'b1;
	endtask
	// Opcode, then parameter; released byte is inverted
	task automatic xfer(input logic [7:0] op, input logic [7:0] par);
		@(posedge sys_clk) bus_in <= op;
		@(posedge sys_clk) cmd_req <= 1'b1;
		wait_ack(1'b1);
		cmd_req <= 1'b0;
		wait_ack(1'b0);
		bus_in <= op[6] ? par : ~op;
		dir_out <= op[6];
		@(posedge sys_clk) par_req <= 1'b1;
		wait_ack(1'b1);
		par_req <= 1'b0;
		wait_ack(1'b0);
		bus_in <= ~bus_in;
	endtask
endmodule
`default_nettype wire

// >>> sim/drive_command_protocol_test.sv
// Bench of the control bus command interpreter
`timescale 1ns/1ps
`default_nettype none
module drive_command_protocol_test;
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	logic act_done = 1'b0;
	logic act_fail = 1'b0;
	logic mech_busy = 1'b0;
	logic spin_strap = 1'b0;
	logic [15:0] cur_cyl = 16'h0000;
	logic cmd_req, par_req, dir_out, hang, ack_q;
	logic bus_out_en, bus_ack, busy, attention, act_start, spin_on, write_en;
	logic read_permit, write_permit;
	logic [1:0] strobe_mode, offset_mode;
	logic [7:0] bus_in, bus_out, act_code, act_param, head_sel;
	logic [15:0] act_cyl, target_cyl, nt;
	logic [23:0] bytes_per_sector, sectors_per_track;
	logic [15:0] notes[$];
	logic [31:0] s = 32'hEE21F8D6;
	logic [7:0] tdo[5] = '{8'h03, 8'h04, 8'h14, 8'h15, 8'h16};
	logic [7:0] md[3] = '{8'h00, 8'h80, 8'hC0};
	int n_fail = 0;
	int checked = 0;
	always #25 sys_clk = ~sys_clk;
	drive_command_protocol drive_command_protocol_i (.sys_clk, .reset_n,
		.clk_en(1'b1), .cmd_req, .par_req, .dir_out, .bus_in, .bus_out,
		.bus_out_en, .bus_ack, .busy, .attention, .spin_strap,
		.mech_busy, .act_done, .act_fail, .cur_cyl, .act_start,
		.act_code, .act_cyl, .act_param, .head_sel, .strobe_mode,
		.offset_mode, .spin_on, .write_en, .target_cyl, .bytes_per_sector,
		.sectors_per_track, .read_permit, .write_permit);
	host_model host_model_i (.sys_clk, .bus_ack, .cmd_req, .par_req,
		.dir_out, .bus_in, .hang);
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task automatic check(input logic [23:0] got, input logic [23:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic results;
		$display("failures %0d checks %0d", n_fail, checked);
		if (n_fail == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic wait_high(ref logic sig);
		int n;
		n = 0;
		while (sig !== 1'b1 && n < 500) begin
			@(posedge sys_clk);
			n++;
		end
		if (n >= 500) begin
			n_fail++;
			results;
		end
	endtask
	// Expected answer and mask noted for parameter-in commands
	task automatic cmd(input logic [7:0] op, par, exp, mask);
		if (!op[6]) notes.push_back({exp, mask});
		host_model_i.xfer(op, par);
	endtask
	always @(posedge sys_clk) begin
		ack_q <= bus_ack;
		if (bus_ack === 1'b1 && ack_q === 1'b0 && bus_out_en === 1'b1) begin
			if (notes.size() == 0) check(bus_out, 24'hFFFFFF);
			else begin
				nt = notes.pop_front();
				check(bus_out & nt[7:0], nt[15:8] & nt[7:0]);
			end
		end
	end
	// Mechanics finish each launched action later
	always @(posedge sys_clk) if (act_start === 1'b1) fork
		begin
			repeat (40) @(posedge sys_clk);
			act_done <= 1'b1;
			@(posedge sys_clk) act_done <= 1'b0;
		end
	join_none
	always @(posedge hang) begin
		n_fail++;
		results;
	end
	initial begin
		repeat (5) @(posedge sys_clk);
		reset_n <= 1'b1;
		repeat (2) @(posedge sys_clk);
		check(spin_on, 1'b1);
		s = lfsr(s);
		cur_cyl <= s[15:0];
		cmd(8'h42, s[31:24], 8'h00, 8'h00);
		cmd(8'h43, s[23:16], 8'h00, 8'h00);
		check(target_cyl, s[31:16]);
		cmd(8'h29, 8'h00, s[15:8], 8'hFF);
		cmd(8'h2A, 8'h00, s[7:0], 8'hFF);
		cmd(8'h6B, s[15:8], 8'h00, 8'h00);
		cmd(8'h6C, s[7:0], 8'h00, 8'h00);
		cmd(8'h2C, 8'h00, s[7:0], 8'hFF);
		check(read_permit, 1'b1);
		cur_cyl <= s[15:0] - 16'h0001;
		@(posedge sys_clk) check(read_permit, 1'b0);
		cmd(8'h41, 8'h80, 8'h00, 8'h00);
		check({write_en, write_permit}, 2'h3);
		cmd(8'h0D, 8'h00, 8'h00, 8'hFF);
		cmd({1'b1, s[6:0]}, 8'h00, 8'h00, 8'h00);
		cmd(8'h0F, 8'h00, 8'h03, 8'h03);
		cmd(8'h01, 8'h00, 8'h00, 8'h00);
		cmd(8'h55, 8'h80, 8'h00, 8'h00);
		cmd(8'h0F, 8'h00, 8'h02, 8'h02);
		cmd(8'h01, 8'h00, 8'h00, 8'h00);
		cmd(8'h0F, 8'h00, 8'h00, 8'h0F);
		cmd(8'h00, 8'h00, 8'h00, 8'h00);
		cmd(8'h0F, 8'h00, 8'h01, 8'h01);
		cmd(8'h02, 8'h00, 8'h00, 8'h00);
		cmd(8'h11, 8'h00, 8'h00, 8'h00);
		check(attention, 1'b1);
		cmd(8'h02, 8'h00, 8'h00, 8'h00);
		foreach (tdo[i]) begin
			cmd(tdo[i], 8'h00, 8'h00, 8'h00);
			check({act_code, attention}, {tdo[i], 1'b0});
			wait_high(attention);
			cmd(8'h02, 8'h00, 8'h00, 8'h00);
			cmd(8'h0F, 8'h00, 8'h00, 8'h0F);
		end
		cmd(8'h03, 8'h00, 8'h00, 8'h00);
		check(act_cyl, s[31:16]);
		cmd(8'h42, ~s[31:24], 8'h00, 8'h00);
		cmd(8'h04, 8'h00, 8'h00, 8'h00);
		cmd(8'h0E, 8'h00, 8'h40, 8'h40);
		check({act_code, act_cyl}, {8'h03, s[31:16]});
		cmd(8'h0F, 8'h00, 8'h09, 8'h0F);
		cmd(8'h01, 8'h00, 8'h00, 8'h00);
		cmd(8'h44, 8'h03, 8'h00, 8'h00);
		check({head_sel, act_param}, 16'h0303);
		act_fail <= 1'b1;
		cmd(8'h44, 8'h01, 8'h00, 8'h00);
		act_fail <= 1'b0;
		cmd(8'h0E, 8'h00, 8'h01, 8'h41);
		cmd(8'h01, 8'h00, 8'h03, 8'h03);
		foreach (md[i]) begin
			cmd(8'h53, md[i], 8'h00, 8'h00);
			check(strobe_mode, i);
			cmd(8'h56 + i, md[i] | i, 8'h00, 8'h00);
			cmd(8'h59 + i, md[i], 8'h00, 8'h00);
		end
		check(bytes_per_sector, 24'h0081C2);
		check(sectors_per_track, 24'h0080C0);
		spin_strap <= 1'b1;
		cmd(8'h55, 8'h00, 8'h00, 8'h00);
		check(spin_on, 1'b0);
		wait_high(attention);
		cmd(8'h02, 8'h00, 8'h00, 8'h00);
		mech_busy <= 1'b1;
		fork
			cmd(8'h0F, 8'h00, 8'h00, 8'h0C);
			begin
				repeat (30) @(posedge sys_clk);
				check({bus_ack, busy}, 2'h1);
				mech_busy <= 1'b0;
			end
		join
		check(notes.size(), 0);
		results;
	end
endmodule
`default_nettype wire
